// *** rtl/ebwsi_arbiter.sv ***
`timescale 1ns/1ps

// fixed priority among pending off-chip requests of one machine cycle
module ebwsi_arbiter
  import ebwsi_pkg::*;
(
  input  wire logic         wr_req,
  input  wire logic         rd_req,
  input  wire logic         pf_req,
  output ebwsi_owner_e      grant
);

  // write before read before fetch
  always_comb begin
    if (wr_req) begin
      grant = EBWSI_OWN_WR; // [R7]
    end else if (rd_req) begin
      grant = EBWSI_OWN_RD; // [R7]
    end else if (pf_req) begin
      grant = EBWSI_OWN_PF;
    end else begin
      grant = EBWSI_OWN_NONE;
    end
  end

endmodule

// *** rtl/ebwsi_defs.svh ***
`ifndef EBWSI_DEFS_SVH
`define EBWSI_DEFS_SVH

// on-chip wait-state configuration register in I/O space
`define EBWSI_WSCFG_ADDR   16'hFFFF
`define EBWSI_WSCFG_RESET  16'h01FF
// per-space wait-count fields of the configuration register
`define EBWSI_WS_W         3
`define EBWSI_PS_LSB       0
`define EBWSI_DS_LSB       3
`define EBWSI_IS_LSB       6
// data-space address bit that marks the externally reachable upper half
`define EBWSI_UPPER_BIT    15
// global window bounds compare on the upper address byte
`define EBWSI_GLB_HI       15
`define EBWSI_GLB_LO       8
`define EBWSI_GLB_NONE     8'h00

`endif

// *** rtl/ebwsi_pkg.sv ***
package ebwsi_pkg;

  // address space of a request
  typedef enum logic [1:0] {
    EBWSI_SP_PROG = 2'b00,
    EBWSI_SP_DATA = 2'b01,
    EBWSI_SP_IO   = 2'b10,
    EBWSI_SP_NONE = 2'b11
  } ebwsi_space_e;

  // which internal request owns the external bus
  typedef enum logic [1:0] {
    EBWSI_OWN_NONE = 2'b00,
    EBWSI_OWN_WR   = 2'b01,
    EBWSI_OWN_RD   = 2'b10,
    EBWSI_OWN_PF   = 2'b11
  } ebwsi_owner_e;

  // external cycle sequencer
  typedef enum logic [2:0] {
    EBWSI_ST_IDLE   = 3'b000,
    EBWSI_ST_WSETUP = 3'b001,
    EBWSI_ST_STROBE = 3'b010,
    EBWSI_ST_SWAIT  = 3'b011,
    EBWSI_ST_RWAIT  = 3'b100,
    EBWSI_ST_CAPT   = 3'b101
  } ebwsi_state_e;

endpackage

// *** rtl/ebwsi_top.sv ***
// How it works
// [R1] Any access to an illegal address pulses the non-maskable interrupt output.
// [R2] Program, data, I/O spaces: 16-bit address and data, one select per space.
// [R3] Only upper 32K data words go off-chip; on-chip memory claims its range first.
// [R4] Upper data half is split local/global by a run-time global window setting.
// [R5] Global data access drives bus request low from the access start.
// [R6] Global memory arbitrates, completes, then raises READY.
// [R7] Same-cycle off-chip requests run write first, then read, then fetch.
// [R8] Read/not-write output shows direction of the current external cycle.
// [R9] Active-low access strobe frames every external cycle.
// [R10] Separate active-low read and write strobes mark the cycle kind.
// [R11] I/O accesses use the same buses and timing, only their select differs.
// [R12] Reads with no wait states requested take a single strobe cycle.
// [R13] Every external write takes at least two output cycles.
// [R14] Write data drive starts and stops half a cycle apart from the strobe.
// [R15] Each wait state adds exactly one output cycle, on cycle boundaries.
// [R16] READY low extends one cycle then resamples; finish only on READY high.
// [R17] READY is ignored for internal accesses.
// [R18] Zero to seven software wait states, per program, data and I/O space.
// [R19] Wait counts live in a configuration register at I/O address FFFFh.
// [R20] Software relying on READY programs at least one software wait state.
// [R21] Software wait states come first, then READY extends cycle by cycle.
`timescale 1ns/1ps
`include "ebwsi_defs.svh"

module ebwsi_top
  import ebwsi_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 16
) (
  input  wire logic              SYS_CLK,
  input  wire logic              RST_N,
  input  wire logic              WR_REQ,
  input  wire logic [1:0]        WR_SPACE,
  input  wire logic [ADDR_W-1:0] WR_ADDR,
  input  wire logic [DATA_W-1:0] WR_DATA,
  input  wire logic              WR_ONCHIP,
  output logic                   WR_DONE,
  input  wire logic              RD_REQ,
  input  wire logic [1:0]        RD_SPACE,
  input  wire logic [ADDR_W-1:0] RD_ADDR,
  input  wire logic              RD_ONCHIP,
  output logic                   RD_DONE,
  output logic [DATA_W-1:0]      RD_DATA,
  input  wire logic              PF_REQ,
  input  wire logic [ADDR_W-1:0] PF_ADDR,
  input  wire logic              PF_ONCHIP,
  output logic                   PF_DONE,
  output logic [DATA_W-1:0]      PF_DATA,
  input  wire logic [7:0]        GLOBAL_WINDOW_CONFIG,
  output logic [ADDR_W-1:0]      EXT_ADDR,
  output logic [DATA_W-1:0]      EXT_DATA_OUT,
  output logic                   EXT_DATA_OE,
  input  wire logic [DATA_W-1:0] EXT_DATA_IN,
  output logic                   PROGRAM_SPACE_SELECT_N,
  output logic                   DATA_SPACE_SELECT_N,
  output logic                   IO_SPACE_SELECT_N,
  output logic                   READ_NOT_WRITE,
  output logic                   ACCESS_STROBE_N,
  output logic                   READ_STROBE_N,
  output logic                   WRITE_STROBE_N,
  output logic                   GLOBAL_BUS_REQUEST_N,
  input  wire logic              READY,
  output logic                   OUTPUT_CYCLE_CLOCK,
  output logic                   NMI_PULSE,
  output logic [15:0]            WAIT_COUNT_CONFIG
);

  typedef struct packed {
    logic              phase;
    ebwsi_state_e      st;
    ebwsi_owner_e      owner;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              oe;
    logic              rnw;
    logic              acc_n;
    logic              rd_n;
    logic              we_n;
    logic              ps_n;
    logic              ds_n;
    logic              is_n;
    logic              br_n;
    logic              nmi;
    logic              wr_done;
    logic              rd_done;
    logic              pf_done;
    logic [DATA_W-1:0] rd_data;
    logic [DATA_W-1:0] pf_data;
    logic [15:0]       wscfg;
    logic              ready_m;
    logic              ready_s;
    logic [DATA_W-1:0] din_m;
    logic [DATA_W-1:0] din_s;
  } ebwsi_top_s;
  localparam ebwsi_top_s RST_VAL = '{
    st:      EBWSI_ST_IDLE,
    owner:   EBWSI_OWN_NONE,
    rnw:     1'b1,
    acc_n:   1'b1,
    rd_n:    1'b1,
    we_n:    1'b1,
    ps_n:    1'b1,
    ds_n:    1'b1,
    is_n:    1'b1,
    br_n:    1'b1,
    wscfg:   `EBWSI_WSCFG_RESET,
    default: '0
  };
  ebwsi_top_s            r;
  ebwsi_top_s            n;
  ebwsi_owner_e          grant;
  ebwsi_space_e          cur_space;
  logic [ADDR_W-1:0]     cur_addr;
  logic                  cur_onchip;
  logic                  cur_write;
  logic                  cur_illegal;
  logic                  cur_global;
  logic                  ws_zero;
  logic                  ws_load;
  logic                  ws_tick;
  logic [`EBWSI_WS_W-1:0] ws_val;
  logic                  boundary;
  logic                  finish_strobe;
  ebwsi_arbiter u_arb (
    .wr_req (WR_REQ),
    .rd_req (RD_REQ),
    .pf_req (PF_REQ),
    .grant  (grant)
  );
  ebwsi_wait_counter #(
    .CNT_W (`EBWSI_WS_W)
  ) u_wcnt (
    .clk      (SYS_CLK),
    .rst_n    (RST_N),
    .load     (ws_load),
    .load_val (ws_val),
    .tick     (ws_tick),
    .zero     (ws_zero)
  );
  // route the granted request's attributes
  always_comb begin
    cur_space  = EBWSI_SP_NONE;
    cur_addr   = '0;
    cur_onchip = 1'b0;
    cur_write  = 1'b0;
    case (grant)
      EBWSI_OWN_WR: begin
        cur_space  = ebwsi_space_e'(WR_SPACE);
        cur_addr   = WR_ADDR;
        cur_onchip = WR_ONCHIP;
        cur_write  = 1'b1;
      end
      EBWSI_OWN_RD: begin
        cur_space  = ebwsi_space_e'(RD_SPACE);
        cur_addr   = RD_ADDR;
        cur_onchip = RD_ONCHIP;
      end
      EBWSI_OWN_PF: begin
        cur_space  = EBWSI_SP_PROG;
        cur_addr   = PF_ADDR;
        cur_onchip = PF_ONCHIP;
      end
      default: cur_space = EBWSI_SP_NONE;
    endcase
  end
  // lower data half belongs to peripherals, so off-chip it is illegal
  assign cur_illegal = (cur_space == EBWSI_SP_NONE) ||
                       ((cur_space == EBWSI_SP_DATA) && !cur_addr[`EBWSI_UPPER_BIT]); // [R3]

  // window value zero leaves the whole upper half local
  assign cur_global = (cur_space == EBWSI_SP_DATA) &&
                      (GLOBAL_WINDOW_CONFIG != `EBWSI_GLB_NONE) &&
                      (cur_addr[`EBWSI_GLB_HI:`EBWSI_GLB_LO] >= GLOBAL_WINDOW_CONFIG); // [R4]
  // software wait count of the granted space
  always_comb begin
    case (cur_space)
      EBWSI_SP_PROG: ws_val = r.wscfg[`EBWSI_PS_LSB +: `EBWSI_WS_W]; // [R18]
      EBWSI_SP_DATA: ws_val = r.wscfg[`EBWSI_DS_LSB +: `EBWSI_WS_W]; // [R18]
      EBWSI_SP_IO:   ws_val = r.wscfg[`EBWSI_IS_LSB +: `EBWSI_WS_W]; // [R18]
      default:       ws_val = '0;
    endcase
  end

  // output cycles are two system clocks; phase 1 is the second half
  assign boundary = r.phase;
  // sequencer: all pin decisions made here, registered below
  always_comb begin
    n             = r;
    n.phase       = ~r.phase;
    n.ready_m     = READY;
    n.ready_s     = r.ready_m;
    n.din_m       = EXT_DATA_IN;
    n.din_s       = r.din_m;
    n.nmi         = 1'b0;
    n.wr_done     = 1'b0;
    n.rd_done     = 1'b0;
    n.pf_done     = 1'b0;
    ws_load       = 1'b0;
    ws_tick       = 1'b0;
    finish_strobe = 1'b0;
    case (r.st)
      EBWSI_ST_IDLE: begin
        if (boundary && (grant != EBWSI_OWN_NONE)) begin
          if (cur_onchip) begin
            // internal memory answers; no external cycle, READY unused
            n.wr_done = (grant == EBWSI_OWN_WR); // [R17]
            n.rd_done = (grant == EBWSI_OWN_RD);
            n.pf_done = (grant == EBWSI_OWN_PF);
          end else if ((cur_space == EBWSI_SP_IO) && (cur_addr == `EBWSI_WSCFG_ADDR)) begin
            // configuration register is internal, READY unused
            if (cur_write) begin
              n.wscfg   = WR_DATA[15:0]; // [R19]
              n.wr_done = 1'b1; // [R17]
            end else begin
              n.rd_data = r.wscfg; // [R19]
              n.rd_done = 1'b1;
            end
          end else if (cur_illegal) begin
            // access is dropped and the interrupt lets software recover
            n.nmi     = 1'b1; // [R1]
            n.wr_done = (grant == EBWSI_OWN_WR);
            n.rd_done = (grant == EBWSI_OWN_RD);
            n.pf_done = (grant == EBWSI_OWN_PF);
          end else begin
            n.owner = grant;
            n.addr  = cur_addr; // [R2]
            n.wdata = WR_DATA;
            n.rnw   = ~cur_write; // [R8]
            n.ps_n  = ~(cur_space == EBWSI_SP_PROG); // [R2]
            n.ds_n  = ~(cur_space == EBWSI_SP_DATA); // [R2]
            n.is_n  = ~(cur_space == EBWSI_SP_IO); // [R11]
            n.br_n  = ~cur_global; // [R5]
            ws_load = 1'b1;
            if (cur_write) begin
              n.st = EBWSI_ST_WSETUP; // [R13]
            end else begin
              n.st    = EBWSI_ST_STROBE; // [R12]
              n.acc_n = 1'b0; // [R9]
              n.rd_n  = 1'b0; // [R10]
            end
          end
        end
      end
      EBWSI_ST_WSETUP: begin
        // extra write cycle; data drive starts half a cycle in
        if (!boundary) begin
          n.oe = 1'b1; // [R14]
        end else begin
          n.st    = EBWSI_ST_STROBE; // [R13]
          n.acc_n = 1'b0; // [R9]
          n.we_n  = 1'b0; // [R10]
        end
      end
      EBWSI_ST_STROBE, EBWSI_ST_SWAIT: begin
        if (boundary) begin
          if (!ws_zero) begin
            ws_tick = 1'b1; // [R21]
            n.st    = EBWSI_ST_SWAIT; // [R15]
          end else if (r.ready_s) begin
            finish_strobe = 1'b1;
          end else begin
            n.st = EBWSI_ST_RWAIT; // [R16]
          end
        end
      end
      EBWSI_ST_RWAIT: begin
        // one cycle per low sample of READY
        if (boundary && r.ready_s) begin
          finish_strobe = 1'b1; // [R16]
        end
      end
      EBWSI_ST_CAPT: begin
        // write drive released half a cycle after the strobe rises
        if (!boundary) begin
          n.oe = 1'b0; // [R14]
        end else begin
          if (r.owner == EBWSI_OWN_RD) begin
            n.rd_data = r.din_s;
          end
          if (r.owner == EBWSI_OWN_PF) begin
            n.pf_data = r.din_s;
          end
          n.wr_done = (r.owner == EBWSI_OWN_WR);
          n.rd_done = (r.owner == EBWSI_OWN_RD);
          n.pf_done = (r.owner == EBWSI_OWN_PF);
          n.owner   = EBWSI_OWN_NONE;
          n.rnw     = 1'b1;
          n.ps_n    = 1'b1;
          n.ds_n    = 1'b1;
          n.is_n    = 1'b1;
          n.br_n    = 1'b1;
          n.st      = EBWSI_ST_IDLE;
        end
      end
      default: n.st = EBWSI_ST_IDLE;
    endcase
    // strobes rise together on a cycle boundary
    if (finish_strobe) begin
      n.acc_n = 1'b1; // [R9]
      n.rd_n  = 1'b1; // [R10]
      n.we_n  = 1'b1; // [R10]
      n.st    = EBWSI_ST_CAPT; // [R15]
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      r <= RST_VAL;
    end else begin
      r <= n;
    end
  end

  // every output straight from the state register
  assign WR_DONE                = r.wr_done;
  assign RD_DONE                = r.rd_done;
  assign RD_DATA                = r.rd_data;
  assign PF_DONE                = r.pf_done;
  assign PF_DATA                = r.pf_data;
  assign EXT_ADDR               = r.addr;
  assign EXT_DATA_OUT           = r.wdata;
  assign EXT_DATA_OE            = r.oe;
  assign PROGRAM_SPACE_SELECT_N = r.ps_n;
  assign DATA_SPACE_SELECT_N    = r.ds_n;
  assign IO_SPACE_SELECT_N      = r.is_n;
  assign READ_NOT_WRITE         = r.rnw;
  assign ACCESS_STROBE_N        = r.acc_n;
  assign READ_STROBE_N          = r.rd_n;
  assign WRITE_STROBE_N         = r.we_n;
  assign GLOBAL_BUS_REQUEST_N   = r.br_n;
  assign OUTPUT_CYCLE_CLOCK     = r.phase;
  assign NMI_PULSE              = r.nmi;
  assign WAIT_COUNT_CONFIG      = r.wscfg;

endmodule

// *** rtl/ebwsi_wait_counter.sv ***
`timescale 1ns/1ps

// down-counter for software wait states, one tick per output cycle
module ebwsi_wait_counter
  import ebwsi_pkg::*;
#(
  parameter int CNT_W = 3
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] load_val,
  input  wire logic             tick,
  output logic                  zero
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } ebwsi_wcnt_s;

  ebwsi_wcnt_s r;
  ebwsi_wcnt_s n;

  // load wins over tick; a tick at zero is held at zero
  always_comb begin
    n = r;
    if (load) begin
      n.cnt = load_val;
    end else if (tick && (r.cnt != '0)) begin
      n.cnt = r.cnt - 1'b1; // [R15]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign zero = (r.cnt == '0);

endmodule

// *** test/ebwsi_ext_mem.sv ***
`timescale 1ns/1ps

// external memory, also standing in for the global arbiter
module ebwsi_ext_mem (
  input  wire logic        clk,
  input  wire logic [15:0] a,
  input  wire logic [15:0] dout,
  input  wire logic        sel_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic        access_strobe_n_n,
  input  wire logic [3:0]  slow,
  output logic [15:0]      din,
  output logic             rdy
);
  logic [15:0] mem [0:255];
  logic [15:0] last = 16'h0000;
  logic [3:0]  cnt = 4'h0;

  // busy count restarts per access; 4'hF means stuck busy
  always @(posedge clk) begin
    if (!wr_n && !sel_n) mem[a[7:0]] <= dout;
    if (!rd_n && !sel_n) last <= mem[a[7:0]];
    if (access_strobe_n_n) cnt <= slow;
    else if (cnt != 4'h0) cnt <= cnt - 4'h1;
  end

  // ready only once the access is complete
  assign rdy = (cnt == 4'h0) && (slow != 4'hF);
  // released bus shows the inverse, never a stale match
  assign din = (!rd_n && !sel_n) ? mem[a[7:0]] : ~last;
endmodule

// *** test/ebwsi_monitor.sv ***
`timescale 1ns/1ps

module ebwsi_monitor (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic EXT_DATA_OE,
  input wire logic PROGRAM_SPACE_SELECT_N,
  input wire logic DATA_SPACE_SELECT_N,
  input wire logic IO_SPACE_SELECT_N,
  input wire logic READ_NOT_WRITE,
  input wire logic ACCESS_STROBE_N,
  input wire logic READ_STROBE_N,
  input wire logic WRITE_STROBE_N,
  input wire logic GLOBAL_BUS_REQUEST_N,
  input wire logic OUTPUT_CYCLE_CLOCK,
  input wire logic NMI_PULSE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  // strobe only frames a cycle that has a space selected
  chk_strobe_sel: assert property (
    !ACCESS_STROBE_N |-> !(PROGRAM_SPACE_SELECT_N & DATA_SPACE_SELECT_N & IO_SPACE_SELECT_N))
    else $error("strobe low with no space selected");
  chk_one_select: assert property (
    $onehot0({!PROGRAM_SPACE_SELECT_N, !DATA_SPACE_SELECT_N, !IO_SPACE_SELECT_N}))
    else $error("more than one space select low");
  chk_read_strobe: assert property (
    !READ_STROBE_N |-> READ_NOT_WRITE && !ACCESS_STROBE_N)
    else $error("read strobe outside a read cycle");
  chk_write_strobe: assert property (
    !WRITE_STROBE_N |-> !READ_NOT_WRITE && !ACCESS_STROBE_N)
    else $error("write strobe outside a write cycle");
  chk_oe_write: assert property (
    EXT_DATA_OE |-> !READ_NOT_WRITE)
    else $error("data driven outside a write");
  // bus turnaround: drive starts before the strobe falls
  chk_oe_lead: assert property (
    $fell(WRITE_STROBE_N) |-> $past(EXT_DATA_OE))
    else $error("write strobe before data drive");
  chk_strobe_len: assert property (
    $fell(ACCESS_STROBE_N) |-> !ACCESS_STROBE_N [*2])
    else $error("strobe shorter than one output cycle");
  chk_strobe_edge: assert property (
    $changed(ACCESS_STROBE_N) |-> !OUTPUT_CYCLE_CLOCK)
    else $error("strobe moved off an output cycle boundary");
  chk_br_data: assert property (
    !GLOBAL_BUS_REQUEST_N |-> !DATA_SPACE_SELECT_N)
    else $error("bus request outside a data access");
  chk_br_start: assert property (
    $fell(GLOBAL_BUS_REQUEST_N) |-> $fell(DATA_SPACE_SELECT_N))
    else $error("bus request late in the access");
  chk_nmi_pulse: assert property (
    NMI_PULSE |-> ACCESS_STROBE_N ##1 !NMI_PULSE)
    else $error("interrupt pulse wrong");

  cov_write: cover property ($fell(WRITE_STROBE_N));
  cov_global: cover property ($fell(GLOBAL_BUS_REQUEST_N));
  cov_nmi: cover property (NMI_PULSE);
endmodule

bind ebwsi_top ebwsi_monitor i_ebwsi_monitor (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .EXT_DATA_OE(EXT_DATA_OE),
  .PROGRAM_SPACE_SELECT_N(PROGRAM_SPACE_SELECT_N), .DATA_SPACE_SELECT_N(DATA_SPACE_SELECT_N),
  .IO_SPACE_SELECT_N(IO_SPACE_SELECT_N), .READ_NOT_WRITE(READ_NOT_WRITE),
  .ACCESS_STROBE_N(ACCESS_STROBE_N), .READ_STROBE_N(READ_STROBE_N),
  .WRITE_STROBE_N(WRITE_STROBE_N), .GLOBAL_BUS_REQUEST_N(GLOBAL_BUS_REQUEST_N),
  .OUTPUT_CYCLE_CLOCK(OUTPUT_CYCLE_CLOCK), .NMI_PULSE(NMI_PULSE)
);

// *** test/tb_top.sv ***
`timescale 1ns/1ps

module tb_top;
  import ebwsi_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        wr_req = 1'b0, rd_req = 1'b0, pf_req = 1'b0;
  logic [1:0]  wr_sp = 2'b01, rd_sp = 2'b01;
  logic [15:0] wr_a = 16'h0, wr_d = 16'h0, rd_a = 16'h0, pf_a = 16'h0;
  logic        wr_oc = 1'b0, rd_oc = 1'b0, pf_oc = 1'b0;
  logic [7:0]  gwin = 8'h00;
  logic [3:0]  slow = 4'h0;
  logic        wr_dn, rd_dn, pf_dn, oe, ps_n, ds_n, is_n, rnw, st_n, rs_n, ws_n;
  logic        br_n, oclk, nmi, rdy;
  logic [15:0] rd_q, pf_q, ea, eo, ei, cfg;
  logic [4:0]  seen;
  logic [5:0]  ord;
  int          miscompares = 0, checks_done = 0, cyc = 0, n;

  ebwsi_top i_ebwsi_top (.SYS_CLK(clk), .RST_N(rst_n), .WR_REQ(wr_req), .WR_SPACE(wr_sp),
    .WR_ADDR(wr_a), .WR_DATA(wr_d), .WR_ONCHIP(wr_oc), .WR_DONE(wr_dn), .RD_REQ(rd_req),
    .RD_SPACE(rd_sp), .RD_ADDR(rd_a), .RD_ONCHIP(rd_oc), .RD_DONE(rd_dn), .RD_DATA(rd_q),
    .PF_REQ(pf_req), .PF_ADDR(pf_a), .PF_ONCHIP(pf_oc), .PF_DONE(pf_dn), .PF_DATA(pf_q),
    .GLOBAL_WINDOW_CONFIG(gwin), .EXT_ADDR(ea), .EXT_DATA_OUT(eo), .EXT_DATA_OE(oe),
    .EXT_DATA_IN(ei), .PROGRAM_SPACE_SELECT_N(ps_n), .DATA_SPACE_SELECT_N(ds_n),
    .IO_SPACE_SELECT_N(is_n), .READ_NOT_WRITE(rnw), .ACCESS_STROBE_N(st_n),
    .READ_STROBE_N(rs_n), .WRITE_STROBE_N(ws_n), .GLOBAL_BUS_REQUEST_N(br_n),
    .READY(rdy), .OUTPUT_CYCLE_CLOCK(oclk), .NMI_PULSE(nmi), .WAIT_COUNT_CONFIG(cfg));

  ebwsi_ext_mem i_ebwsi_ext_mem (.clk(clk), .a(ea), .dout(eo), .sel_n(ps_n & ds_n & is_n),
    .rd_n(rs_n), .wr_n(ws_n), .access_strobe_n_n(st_n), .slow(slow), .din(ei), .rdy(rdy));

  always #25 clk = ~clk;

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // m picks write/read/fetch; requests dropped as each one completes
  task automatic acc(input logic [2:0] m, input logic [1:0] sp, input logic [15:0] a, d,
                     input logic oc);
    @(negedge clk);
    while (oclk !== 1'b1) @(negedge clk);
    {wr_sp, rd_sp, wr_a, rd_a, pf_a, wr_d} = {sp, sp, a, a, a, d};
    {wr_oc, rd_oc, pf_oc} = {3{oc}};
    {wr_req, rd_req, pf_req} = m;
    n = 0;
    ord = 6'h00;
    seen = 5'h00;
    while ((wr_req | rd_req | pf_req) && n < 80) begin
      @(negedge clk);
      n++;
      seen |= {nmi, ~br_n, ~ps_n, ~ds_n, ~is_n};
      if (wr_dn | rd_dn | pf_dn) ord = {ord[3:0], wr_dn ? 2'd1 : rd_dn ? 2'd2 : 2'd3};
      {wr_req, rd_req, pf_req} &= ~{wr_dn, rd_dn, pf_dn};
    end
    repeat (2) @(negedge clk);
  endtask

  task t_reset;
    chk("config", 16'h01FF, cfg);
    chk("pins", 16'h01FE, {7'h0, ps_n, ds_n, is_n, st_n, rs_n, ws_n, br_n, rnw, oe});
    $display("test reset done");
  endtask

  task t_config;
    acc(3'b100, 2'b10, 16'hFFFF, 16'hA040, 1'b0);
    chk("cfg write cycles", 16'd1, 16'(n));
    chk("cfg value", 16'hA040, cfg);
    acc(3'b010, 2'b10, 16'hFFFF, 16'h0000, 1'b0);
    chk("cfg read back", 16'hA040, rd_q);
    $display("test config done");
  endtask

  task t_spaces;
    acc(3'b100, 2'b01, 16'h8010, 16'h1234, 1'b0);
    chk("write cycles", 16'd7, 16'(n));
    acc(3'b010, 2'b01, 16'h8010, 16'h0000, 1'b0);
    chk("read cycles", 16'd5, 16'(n));
    chk("read data", 16'h1234, rd_q);
    chk("data select", 16'h02, 16'(seen));
    acc(3'b010, 2'b10, 16'h0010, 16'h0000, 1'b0);
    chk("io cycles", 16'd7, 16'(n));
    chk("io data", 16'h1234, rd_q);
    chk("io select", 16'h01, 16'(seen));
    acc(3'b001, 2'b00, 16'h0010, 16'h0000, 1'b0);
    chk("fetch data", 16'h1234, pf_q);
    chk("fetch select", 16'h04, 16'(seen));
    $display("test spaces done");
  endtask

  task t_waits;
    acc(3'b100, 2'b10, 16'hFFFF, 16'hA058, 1'b0);
    acc(3'b010, 2'b01, 16'h8010, 16'h0000, 1'b0);
    chk("three waits", 16'd11, 16'(n));
    // one software wait on data before relying on READY
    acc(3'b100, 2'b10, 16'hFFFF, 16'hA048, 1'b0);
    slow = 4'h6;
    acc(3'b010, 2'b01, 16'h8010, 16'h0000, 1'b0);
    chk("ready stretch", 16'h1, 16'(n > 8 && n < 40));
    chk("ready data", 16'h1234, rd_q);
    slow = 4'hF;
    acc(3'b010, 2'b01, 16'h8010, 16'h0000, 1'b1);
    chk("onchip cycles", 16'd1, 16'(n));
    chk("onchip pins", 16'h00, 16'(seen));
    slow = 4'h0;
    $display("test waits done");
  endtask

  task t_order;
    acc(3'b100, 2'b10, 16'hFFFF, 16'hA000, 1'b0);
    acc(3'b111, 2'b01, 16'h8020, 16'hBEEF, 1'b0);
    chk("order", 16'h1B, 16'(ord));
    chk("read after write", 16'hBEEF, rd_q);
    chk("fetch last", 16'hBEEF, pf_q);
    $display("test order done");
  endtask

  task t_global;
    gwin = 8'h80;
    acc(3'b010, 2'b01, 16'h8020, 16'h0000, 1'b0);
    chk("global request", 16'h0A, 16'(seen));
    gwin = 8'hC0;
    acc(3'b010, 2'b01, 16'h8020, 16'h0000, 1'b0);
    chk("local window", 16'h02, 16'(seen));
    acc(3'b010, 2'b01, 16'h0100, 16'h0000, 1'b0);
    chk("illegal data", 16'h10, 16'(seen));
    acc(3'b100, 2'b11, 16'h8010, 16'h0000, 1'b0);
    chk("illegal space", 16'h10, 16'(seen));
    chk("illegal cycles", 16'd1, 16'(n));
    $display("test global done");
  endtask

  task summarize;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // hang guard, far above the fewer than two hundred cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      summarize();
    end
  end

  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_reset();
    t_config();
    t_spaces();
    t_waits();
    t_order();
    t_global();
    summarize();
  end
endmodule
